/* File: i2c_link_if.sv */
`timescale 1ns/1ns
interface i2c_link_if;
	logic scl;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic sda;

	// open drain: any enabled driver at zero pulls the line low
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

	modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
	modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface : i2c_link_if

/* File: sync2.sv */
`timescale 1ns/1ns
module sync2 (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// level in and synchronised level out
	input  wire logic d,
	output logic      q
);
	logic s1_ff;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s1_ff <= 1'b0;
			q     <= 1'b0;
		end
		else
		begin
			s1_ff <= d;
			q     <= s1_ff;
		end
	end
endmodule : sync2

/* File: touch_cmd_device.sv */
`timescale 1ns/1ns
`include "touch_cmd_params.svh"

// Operation
// - host writes address, index A0, code
// - stay deaf for command's busy time
// - revision and status queries, no busy
// - save and factory restore, 120 ms
// - write defaults 120 ms, reconfigure setup only
// - read stored defaults, 5 ms
// - present working configuration, 5 ms
// - normal mode, no busy time
// - setup mode, wait scaled loop time
// - host waits four times at low voltage
// - host avoids save at fast sleep
// - command register accepts writes only
module touch_cmd_device #(
	parameter touch_cmd_pkg::cycles_t T_NVM_CYC   = `T_NVM_MS * `CLK_PER_MS,
	parameter touch_cmd_pkg::cycles_t T_SCAN_CYC  = `T_SCAN_ON_MS * `CLK_PER_MS,
	parameter touch_cmd_pkg::cycles_t T_SHORT_CYC = `T_SHORT_MS * `CLK_PER_MS,
	parameter touch_cmd_pkg::cycles_t T_SETUP_CYC =
		(`LOOP_US + `SETUP_PAD_US) * `SETUP_NUM / `SETUP_DEN * `CLK_PER_US
) (
	// link
	i2c_link_if.dev   LINK,
	// clock and reset
	input  wire logic CLK,
	input  wire logic RSTN,
	// command events
	output logic      EV_REV,
	output logic      EV_SAVE,
	output logic      EV_FACTORY,
	output logic      EV_WR_POR,
	output logic      EV_RD_POR,
	output logic      EV_RD_RAM,
	output logic      EV_RECONF,
	output logic      EV_STATUS,
	// state
	output logic      SETUP_MODE,
	output logic      SCANNING,
	output logic      BUSY,
	output logic [7:0] REV_DATA,
	output logic [7:0] STATUS_DATA
);
	// link domain: all state except sda_p_ff moves on the falling edge of scl
	logic       sda_p_ff;
	logic       lr1_ff;
	logic       lr2_ff;
	logic       lb1_ff;
	logic       lb2_ff;
	logic       act_ff;
	logic [4:0] cnt_ff;
	logic [6:0] shift_ff;
	logic [7:0] code_ff;
	logic       tog_ff;
	logic       oe_ff;

	// system domain
	logic                   lrst_ff;
	logic                   tog_seen_ff;
	logic                   setup_ff;
	logic                   scan_ff;
	touch_cmd_pkg::cycles_t busy_cnt_ff;
	logic                   busy_ff;

	wire       start_seen = sda_p_ff & ~LINK.sda;
	wire [7:0] byte_in    = {shift_ff, sda_p_ff};
	wire       addr_ok    = byte_in[7:1] == `DEV_ADDR && byte_in[0] == `RW_WRITE && !lb2_ff;
	wire       index_ok   = byte_in == `CMD_INDEX;

	assign LINK.sda_d_o  = 1'b0;
	assign LINK.sda_d_oe = oe_ff;

	// level of sda while scl is high
	always_ff @(posedge LINK.scl)
	begin
		sda_p_ff <= LINK.sda;
	end

	always_ff @(negedge LINK.scl)
	begin
		lr1_ff <= lrst_ff;
		lr2_ff <= lr1_ff;
		lb1_ff <= busy_ff | lrst_ff;
		lb2_ff <= lb1_ff;
		if (lr2_ff)
		begin
			act_ff   <= 1'b0;
			cnt_ff   <= 5'h00;
			shift_ff <= 7'h00;
			code_ff  <= 8'h00;
			tog_ff   <= 1'b0;
			oe_ff    <= 1'b0;
		end
		else if (start_seen)
		begin
			act_ff   <= 1'b1;
			cnt_ff   <= 5'h00;
			shift_ff <= 7'h00;
			oe_ff    <= 1'b0;
		end
		else if (act_ff)
		begin
			shift_ff <= byte_in[6:0];
			cnt_ff   <= cnt_ff + 5'h01;
			unique case (cnt_ff)
				`BYTE_ADDR:
				begin
					// deaf while busy; reads are not acknowledged
					oe_ff  <= addr_ok;
					act_ff <= addr_ok;
				end
				`BYTE_INDEX:
				begin
					oe_ff  <= index_ok;
					act_ff <= index_ok;
				end
				`BYTE_CODE:
				begin
					oe_ff   <= 1'b1;
					code_ff <= byte_in;
					tog_ff  <= ~tog_ff;
				end
				`ACK_ADDR, `ACK_INDEX:
				begin
					oe_ff <= 1'b0;
				end
				`BIT_LAST:
				begin
					oe_ff  <= 1'b0;
					act_ff <= 1'b0;
				end
				default:
				begin
					oe_ff <= 1'b0;
				end
			endcase
		end
		else
		begin
			oe_ff <= 1'b0;
		end
	end

	// crossings into the system domain
	logic tog_s;
	logic lr_s;

	sync2 u_tog (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (tog_ff),
		.q    (tog_s)
	);

	sync2 u_lrst (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (lr2_ff),
		.q    (lr_s)
	);

	// link side holds no defined state until its reset hand-over is complete
	wire cmd_ev     = (tog_s ^ tog_seen_ff) & ~(lrst_ff | lr_s);
	wire known      = code_ff <= `CODE_STATUS;
	wire setup_only = code_ff == `CODE_RECONF;
	wire accept     = cmd_ev & known & ~(setup_only & ~setup_ff);

	wire touch_cmd_pkg::cycles_t load_cyc =
		touch_cmd_pkg::wait_cycles(code_ff, T_NVM_CYC, T_SCAN_CYC, T_SHORT_CYC, T_SETUP_CYC);

	wire touch_cmd_pkg::cycles_t nxt_busy_cnt =
		accept ? load_cyc : (busy_cnt_ff != '0 ? busy_cnt_ff - 32'h0000_0001 : busy_cnt_ff);

	wire nxt_setup =
		(accept && code_ff == `CODE_SETUP)  ? 1'b1 :
		(accept && code_ff == `CODE_NORMAL) ? 1'b0 :
		setup_ff;

	wire nxt_scan =
		(accept && code_ff == `CODE_SCAN_ON)  ? 1'b1 :
		(accept && code_ff == `CODE_SCAN_OFF) ? 1'b0 :
		scan_ff;

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			lrst_ff     <= 1'b1;
			tog_seen_ff <= 1'b0;
			setup_ff    <= 1'b0;
			scan_ff     <= 1'b1;
			busy_cnt_ff <= '0;
			busy_ff     <= 1'b0;
		end
		else
		begin
			// link reset held until the link domain has taken it;
			// cleared only on a clean echo, never by an unknown one
			if (lr_s)
			begin
				lrst_ff <= 1'b0;
			end
			tog_seen_ff <= tog_s;
			setup_ff    <= nxt_setup;
			scan_ff     <= nxt_scan;
			busy_cnt_ff <= nxt_busy_cnt;
			busy_ff     <= nxt_busy_cnt != '0;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			EV_REV      <= 1'b0;
			EV_SAVE     <= 1'b0;
			EV_FACTORY  <= 1'b0;
			EV_WR_POR   <= 1'b0;
			EV_RD_POR   <= 1'b0;
			EV_RD_RAM   <= 1'b0;
			EV_RECONF   <= 1'b0;
			EV_STATUS   <= 1'b0;
			SETUP_MODE  <= 1'b0;
			SCANNING    <= 1'b1;
			BUSY        <= 1'b1;
			REV_DATA    <= 8'h00;
			STATUS_DATA <= 8'h00;
		end
		else
		begin
			EV_REV      <= accept && code_ff == `CODE_REV;
			EV_SAVE     <= accept && code_ff == `CODE_SAVE;
			EV_FACTORY  <= accept && code_ff == `CODE_FACTORY;
			EV_WR_POR   <= accept && code_ff == `CODE_WR_POR;
			EV_RD_POR   <= accept && code_ff == `CODE_RD_POR;
			EV_RD_RAM   <= accept && code_ff == `CODE_RD_RAM;
			EV_RECONF   <= accept && code_ff == `CODE_RECONF;
			EV_STATUS   <= accept && code_ff == `CODE_STATUS;
			SETUP_MODE  <= nxt_setup;
			SCANNING    <= nxt_scan;
			BUSY        <= (nxt_busy_cnt != '0) | lrst_ff;
			if (accept && code_ff == `CODE_REV)
			begin
				REV_DATA <= `FW_REV;
			end
			if (accept && code_ff == `CODE_STATUS)
			begin
				STATUS_DATA <= {6'h00, nxt_setup, nxt_scan};
			end
		end
	end
endmodule : touch_cmd_device

/* File: touch_cmd_host.sv */
`timescale 1ns/1ns
`include "touch_cmd_params.svh"

module touch_cmd_host #(
	parameter touch_cmd_pkg::cycles_t T_NVM_CYC   = `T_NVM_MS * `CLK_PER_MS,
	parameter touch_cmd_pkg::cycles_t T_SCAN_CYC  = `T_SCAN_ON_MS * `CLK_PER_MS,
	parameter touch_cmd_pkg::cycles_t T_SHORT_CYC = `T_SHORT_MS * `CLK_PER_MS,
	parameter touch_cmd_pkg::cycles_t T_SETUP_CYC =
		(`LOOP_US + `SETUP_PAD_US) * `SETUP_NUM / `SETUP_DEN * `CLK_PER_US
) (
	// link
	i2c_link_if.host  LINK,
	// clock and reset
	input  wire logic CLK,
	input  wire logic RSTN,
	// command request
	input  wire logic       CMD_VALID,
	input  wire logic [7:0] CMD_CODE,
	output logic            CMD_READY,
	// operating conditions
	input  wire logic       LOW_VOLT,
	input  wire logic       SLEEP_FAST,
	// completion
	output logic            DONE,
	output logic            ERR_NACK,
	output logic            ERR_REFUSED
);
	touch_cmd_pkg::host_state_t state_ff;
	logic [1:0]                 qtr_ff;
	logic [1:0]                 ph_ff;
	logic [4:0]                 bit_ff;
	logic [26:0]                frame_ff;
	logic [7:0]                 code_ff;
	logic                       nack_ff;
	logic                       scl_ff;
	logic                       oe_ff;
	touch_cmd_pkg::cycles_t     wait_ff;
	logic                       sda_s;

	sync2 u_sda (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (LINK.sda),
		.q    (sda_s)
	);

	assign LINK.scl     = scl_ff;
	assign LINK.sda_h_o = 1'b0;
	assign LINK.sda_h_oe = oe_ff;

	wire tick     = qtr_ff == `QTR_LAST;
	wire ph_last  = ph_ff == `QTR_LAST;
	wire take     = CMD_VALID & CMD_READY;
	wire refuse   = CMD_CODE == `CODE_SAVE && SLEEP_FAST;
	wire is_ack   = bit_ff == `ACK_ADDR || bit_ff == `ACK_INDEX || bit_ff == `BIT_LAST;
	wire bit_val  = frame_ff[26];

	wire touch_cmd_pkg::cycles_t base_wait =
		touch_cmd_pkg::wait_cycles(code_ff, T_NVM_CYC, T_SCAN_CYC, T_SHORT_CYC, T_SETUP_CYC);
	wire touch_cmd_pkg::cycles_t full_wait =
		LOW_VOLT ? base_wait << `LOW_V_SHIFT : base_wait;

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			state_ff    <= touch_cmd_pkg::H_INIT;
			qtr_ff      <= 2'h0;
			ph_ff       <= 2'h0;
			bit_ff      <= 5'h00;
			frame_ff    <= '0;
			code_ff     <= 8'h00;
			nack_ff     <= 1'b0;
			scl_ff      <= 1'b1;
			oe_ff       <= 1'b0;
			wait_ff     <= '0;
			CMD_READY   <= 1'b0;
			DONE        <= 1'b0;
			ERR_NACK    <= 1'b0;
			ERR_REFUSED <= 1'b0;
		end
		else
		begin
			DONE        <= 1'b0;
			qtr_ff      <= qtr_ff + 2'h1;
			if (tick)
			begin
				ph_ff <= ph_ff + 2'h1;
			end
			unique case (state_ff)
				touch_cmd_pkg::H_INIT:
				begin
					// idle pulses with sda high bring the device link out of reset
					if (tick)
					begin
						scl_ff <= ph_ff[1];
						if (ph_last)
						begin
							bit_ff <= bit_ff + 5'h01;
							if (bit_ff == `INIT_PULSES)
							begin
								state_ff  <= touch_cmd_pkg::H_IDLE;
								CMD_READY <= 1'b1;
							end
						end
					end
				end
				touch_cmd_pkg::H_IDLE:
				begin
					ph_ff  <= 2'h0;
					qtr_ff <= 2'h0;
					if (take)
					begin
						CMD_READY   <= 1'b0;
						code_ff     <= CMD_CODE;
						ERR_NACK    <= 1'b0;
						ERR_REFUSED <= refuse;
						nack_ff     <= 1'b0;
						bit_ff      <= 5'h00;
						// address, write, ack, index, ack, code, ack
						frame_ff    <= {`DEV_ADDR, `RW_WRITE, 1'b1, `CMD_INDEX, 1'b1,
							CMD_CODE, 1'b1};
						if (refuse)
						begin
							DONE      <= 1'b1;
							CMD_READY <= 1'b1;
						end
						else
						begin
							state_ff <= touch_cmd_pkg::H_START;
						end
					end
				end
				touch_cmd_pkg::H_START:
				begin
					if (tick)
					begin
						unique case (ph_ff)
							2'h0:    scl_ff <= 1'b0;
							2'h1:    scl_ff <= 1'b1;
							2'h2:    oe_ff  <= 1'b1;
							default:
							begin
								scl_ff   <= 1'b0;
								state_ff <= touch_cmd_pkg::H_BITS;
							end
						endcase
					end
				end
				touch_cmd_pkg::H_BITS:
				begin
					if (tick)
					begin
						unique case (ph_ff)
							2'h0:    oe_ff  <= ~bit_val;
							2'h1:    scl_ff <= 1'b1;
							2'h2:    nack_ff <= is_ack & sda_s;
							default:
							begin
								scl_ff   <= 1'b0;
								frame_ff <= {frame_ff[25:0], 1'b1};
								bit_ff   <= bit_ff + 5'h01;
								if (nack_ff || bit_ff == `BIT_LAST)
								begin
									state_ff <= touch_cmd_pkg::H_STOP;
								end
							end
						endcase
					end
				end
				touch_cmd_pkg::H_STOP:
				begin
					if (tick)
					begin
						unique case (ph_ff)
							2'h0:    oe_ff  <= 1'b1;
							2'h1:    scl_ff <= 1'b1;
							2'h2:    oe_ff  <= 1'b0;
							default:
							begin
								ERR_NACK <= nack_ff;
								wait_ff  <= nack_ff ? '0 : full_wait;
								state_ff <= touch_cmd_pkg::H_WAIT;
							end
						endcase
					end
				end
				touch_cmd_pkg::H_WAIT:
				begin
					// device is deaf until its busy time has run out
					if (wait_ff == '0)
					begin
						DONE      <= 1'b1;
						CMD_READY <= 1'b1;
						state_ff  <= touch_cmd_pkg::H_IDLE;
					end
					else
					begin
						wait_ff <= wait_ff - 32'h0000_0001;
					end
				end
			endcase
		end
	end
endmodule : touch_cmd_host

/* File: touch_cmd_params.svh */
`ifndef TOUCH_CMD_PARAMS_SVH
`define TOUCH_CMD_PARAMS_SVH

// addressing of one command transfer
`define DEV_ADDR        7'h00
`define CMD_INDEX       8'hA0

// command codes
`define CODE_REV        8'h00
`define CODE_SAVE       8'h01
`define CODE_FACTORY    8'h02
`define CODE_WR_POR     8'h03
`define CODE_RD_POR     8'h04
`define CODE_RD_RAM     8'h05
`define CODE_RECONF     8'h06
`define CODE_NORMAL     8'h07
`define CODE_SETUP      8'h08
`define CODE_SCAN_ON    8'h09
`define CODE_SCAN_OFF   8'h0A
`define CODE_STATUS     8'h0B

// unavailability after acknowledge
`define T_NVM_MS        120
`define T_SCAN_ON_MS    10
`define T_SHORT_MS      5
`define LOOP_US         2000
`define SETUP_PAD_US    1000
`define SETUP_NUM       12
`define SETUP_DEN       10
`define LOW_V_SHIFT     2
`define CLK_PER_MS      100000
`define CLK_PER_US      100

// link framing: three bytes, each followed by an acknowledge bit
`define BIT_LAST        5'h1A
`define ACK_ADDR        5'h08
`define ACK_INDEX       5'h11
`define BYTE_ADDR       5'h07
`define BYTE_INDEX      5'h10
`define BYTE_CODE       5'h19
`define INIT_PULSES     5'h08
`define QTR_LAST        2'h3
`define RW_WRITE        1'b0

// arbitrary revision value
`define FW_REV          8'h11

`endif

/* File: touch_cmd_pkg.sv */
`include "touch_cmd_params.svh"

package touch_cmd_pkg;

	typedef enum logic [5:0] {
		H_INIT  = 6'b00_0001,
		H_IDLE  = 6'b00_0010,
		H_START = 6'b00_0100,
		H_BITS  = 6'b00_1000,
		H_STOP  = 6'b01_0000,
		H_WAIT  = 6'b10_0000
	} host_state_t;

	typedef logic [31:0] cycles_t;

	// busy time of a command in clock cycles
	function automatic cycles_t wait_cycles(
		input logic [7:0] code,
		input cycles_t    t_nvm,
		input cycles_t    t_scan,
		input cycles_t    t_short,
		input cycles_t    t_setup
	);
		cycles_t r;
		r = '0;
		case (code)
			`CODE_SAVE, `CODE_FACTORY, `CODE_WR_POR:               r = t_nvm;
			`CODE_RD_POR, `CODE_RD_RAM, `CODE_RECONF, `CODE_SCAN_OFF: r = t_short;
			`CODE_SCAN_ON:                                          r = t_scan;
			`CODE_SETUP:                                            r = t_setup;
			default:                                                r = '0;
		endcase
		return r;
	endfunction : wait_cycles

endpackage : touch_cmd_pkg

/* File: touch_cmd_props.sv */
`timescale 1ns/1ns
`include "touch_cmd_params.svh"
module touch_cmd_props (
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// link wires
	input wire logic scl,
	input wire logic sda_h_oe,
	input wire logic sda_d_oe,
	input wire logic sda
);
	logic       scl_ff;
	logic       sda_ff;
	logic       act_ff;
	logic [4:0] nbit_ff;
	wire [7:0]  idx      = `CMD_INDEX;
	wire        start    = scl & scl_ff & sda_ff & ~sda;
	wire        stop     = scl & scl_ff & ~sda_ff & sda;
	wire        rise     = scl & ~scl_ff;
	wire        nxt_act  = start | (act_ff & ~stop);
	wire [4:0]  nxt_nbit = start ? 5'h00 : nbit_ff + {4'h0, rise};
	// data bits of a frame, acknowledge slots left out
	wire        in_data  = act_ff && nbit_ff != 5'h00 && nbit_ff < 5'h1B
		&& nbit_ff != 5'h09 && nbit_ff != 5'h12;
	always_ff @(posedge CLK)
	begin
		scl_ff  <= RSTN ? scl : 1'b1;
		sda_ff  <= RSTN ? sda : 1'b1;
		act_ff  <= RSTN & nxt_act;
		nbit_ff <= RSTN ? nxt_nbit : 5'h00;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_ack_slot;
		$rose(sda_d_oe) |-> act_ff && (nbit_ff == 5'h08 || nbit_ff == 5'h11 || nbit_ff == 5'h1A);
	endproperty
	a_ack_slot: assert property (p_ack_slot)
		else $error("acknowledge outside its slot");
	property p_ack_len;
		$rose(sda_d_oe) |-> sda_d_oe [*8] ##1 sda_d_oe [*7] ##[1:2] !sda_d_oe;
	endproperty
	a_ack_len: assert property (p_ack_len)
		else $error("acknowledge not one bit long");
	property p_ack_edge;
		$changed(sda_d_oe) |-> !scl;
	endproperty
	a_ack_edge: assert property (p_ack_edge)
		else $error("device data changed with clock high");
	property p_addr_bits;
		act_ff && rise && nbit_ff < 5'h08 |-> !sda;
	endproperty
	a_addr_bits: assert property (p_addr_bits)
		else $error("address or direction bit not zero");
	property p_index_bits;
		act_ff && rise && nbit_ff > 5'h08 && nbit_ff < 5'h11 |-> sda == idx[5'h10 - nbit_ff];
	endproperty
	a_index_bits: assert property (p_index_bits)
		else $error("register index bit wrong");
	property p_start_form;
		start |-> scl [*4] ##1 !scl;
	endproperty
	a_start_form: assert property (p_start_form)
		else $error("start condition malformed");
	property p_data_stable;
		in_data && scl && scl_ff |-> sda == sda_ff;
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data changed while clock high");
	property p_stop_after_frame;
		act_ff && nbit_ff == 5'h1B && scl_ff && !scl |-> ##[1:16] stop;
	endproperty
	a_stop_after_frame: assert property (p_stop_after_frame)
		else $error("no stop after code byte");
	c_frame: cover property (act_ff && nbit_ff == 5'h1A && $rose(sda_d_oe));
	c_start: cover property (start);
	c_stop: cover property (stop);
endmodule : touch_cmd_props

/* File: touch_sensor_command_executor_tb.sv */
`timescale 1ns/1ns
`include "touch_cmd_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module touch_sensor_command_executor_tb;
	localparam int TN = 40;
	localparam int TS = 20;
	localparam int TH = 10;
	localparam int TU = 30;
	localparam logic [7:0] DIR [0:16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h06, 8'h0C, 8'hFF, 8'h07, 8'h06};
	logic        clk;
	logic        rstn;
	logic        cmd_valid;
	logic        low_volt;
	logic        sleep_fast;
	logic [7:0]  cmd_code;
	logic        cmd_ready;
	logic        done;
	logic        err_nack;
	logic        err_refused;
	logic [7:0]  ev;
	logic        setup_mode;
	logic        scanning;
	logic        busy;
	logic [7:0]  rev_data;
	logic [7:0]  status_data;
	logic        setup_m;
	logic        scan_m;
	logic [31:0] r;
	int          n_mismatch;
	int          comparisons;
	int          seed;
	int          base;
	int          ev_cnt [8];
	int          exp_cnt [8];
	i2c_link_if link ();
	touch_cmd_host #(.T_NVM_CYC(TN), .T_SCAN_CYC(TS), .T_SHORT_CYC(TH), .T_SETUP_CYC(TU))
	u_touch_cmd_host (.LINK(link), .CLK(clk), .RSTN(rstn), .CMD_VALID(cmd_valid),
		.CMD_CODE(cmd_code), .CMD_READY(cmd_ready), .LOW_VOLT(low_volt),
		.SLEEP_FAST(sleep_fast), .DONE(done), .ERR_NACK(err_nack), .ERR_REFUSED(err_refused));
	touch_cmd_device #(.T_NVM_CYC(TN), .T_SCAN_CYC(TS), .T_SHORT_CYC(TH), .T_SETUP_CYC(TU))
	u_touch_cmd_device (.LINK(link), .CLK(clk), .RSTN(rstn), .EV_REV(ev[0]),
		.EV_SAVE(ev[1]), .EV_FACTORY(ev[2]), .EV_WR_POR(ev[3]), .EV_RD_POR(ev[4]),
		.EV_RD_RAM(ev[5]), .EV_RECONF(ev[6]), .EV_STATUS(ev[7]), .SETUP_MODE(setup_mode),
		.SCANNING(scanning), .BUSY(busy), .REV_DATA(rev_data), .STATUS_DATA(status_data));
	touch_cmd_props u_touch_cmd_props (.CLK(clk), .RSTN(rstn), .scl(link.scl),
		.sda_h_oe(link.sda_h_oe), .sda_d_oe(link.sda_d_oe), .sda(link.sda));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk)
		for (int i = 0; i < 8; i++)
			if (ev[i] === 1'b1)
				ev_cnt[i]++;
	function automatic int host_wait(input logic [7:0] c);
		case (c)
			`CODE_SAVE, `CODE_FACTORY, `CODE_WR_POR: return TN;
			`CODE_RD_POR, `CODE_RD_RAM, `CODE_RECONF, `CODE_SCAN_OFF: return TH;
			`CODE_SCAN_ON: return TS;
			`CODE_SETUP: return TU;
			default: return 0;
		endcase
	endfunction : host_wait
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic run_cmd(input logic [7:0] c, input logic lv, input logic sf);
		int   n;
		int   bn;
		int   bw;
		int   w;
		logic ok;
		logic refused;
		refused = (c == `CODE_SAVE) && sf;
		ok = !refused && c <= 8'h0B && !(c == `CODE_RECONF && !setup_m);
		w = host_wait(c);
		n = 0;
		@(posedge clk);
		#1;
		while (cmd_ready !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		cmd_valid = 1'b1;
		cmd_code = c;
		low_volt = lv;
		sleep_fast = sf;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		n = 0;
		bn = 0;
		while (done !== 1'b1 && n < 5000)
		begin
			bn += (busy === 1'b1);
			@(posedge clk);
			#1;
			n++;
		end
		if (ok && (c <= 8'h06 || c == `CODE_STATUS))
			exp_cnt[(c == `CODE_STATUS) ? 7 : int'(c)]++;
		if (ok && c == `CODE_NORMAL)
			setup_m = 1'b0;
		if (ok && c == `CODE_SETUP)
			setup_m = 1'b1;
		if (ok && c == `CODE_SCAN_ON)
			scan_m = 1'b1;
		if (ok && c == `CODE_SCAN_OFF)
			scan_m = 1'b0;
		`CHK(err_refused, refused)
		`CHK(err_nack, 1'b0)
		`CHK(setup_mode, setup_m)
		`CHK(scanning, scan_m)
		for (int i = 0; i < 8; i++)
			`CHK(ev_cnt[i], exp_cnt[i])
		if (refused)
			`CHK(n <= 1, 1'b1)
		else
		begin
			bw = ok ? w : 0;
			`CHK(bn >= bw && bn <= bw + 2, 1'b1)
			if (base < 0)
				base = n - (lv ? 4 * w : w);
			`CHK(n, base + (lv ? 4 * w : w))
		end
		if (c == `CODE_REV)
			`CHK(rev_data, `FW_REV)
		if (c == `CODE_STATUS)
			`CHK(status_data, {6'h00, setup_m, scan_m})
	endtask : run_cmd
	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		$display("watchdog expired");
		stop_test;
	end
	initial
	begin
		seed = 32'hf507_0833;
		base = -1;
		setup_m = 1'b0;
		scan_m = 1'b1;
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		low_volt = 1'b0;
		sleep_fast = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rstn = 1'b1;
		foreach (DIR[i])
			run_cmd(DIR[i], 1'b0, 1'b0);
		run_cmd(`CODE_SAVE, 1'b0, 1'b1);
		run_cmd(`CODE_SCAN_OFF, 1'b1, 1'b0);
		$display("test directed done");
		for (int k = 0; k < 30; k++)
		begin
			r = $random(seed);
			run_cmd(r[7:0] % 8'h0E, r[8], r[9]);
		end
		$display("test random done");
		stop_test;
	end
endmodule : touch_sensor_command_executor_tb
